// ---- shared/pcs_regs.svh ----
// Purpose: Constants for the card socket interface: strobe positions, widths, reset values.
// Assumes: Included by bare name after the package.
// Notes:   Strobes are active low; all-ones means every strobe deasserted.
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

`define PCS_ADDR_W     26
`define PCS_DATA_W     16
`define PCS_NSTROBE    7
`define PCS_STB_CE1    0
`define PCS_STB_CE2    1
`define PCS_STB_IOR    2
`define PCS_STB_IOW    3
`define PCS_STB_WE     4
`define PCS_STB_OE     5
`define PCS_STB_REG    6
`define PCS_STB_IDLE   7'h7f
`define PCS_NPWR       4
`define PCS_PWR_RST    4'h0
`define PCS_NIRQ       6
`define PCS_IRQ_RST    6'h3f

`endif

// ---- shared/pcs_pkg.sv ----
// Purpose: Shared types for the card socket interface.
// Assumes: Nothing is imported; users write pcs_pkg::name.
// Notes:   Strobe vector order is given in pcs_regs.svh.
package pcs_pkg;
  typedef enum logic {PCS_SOCK0, PCS_SOCK1} pcs_sock_t;
  typedef logic [6:0] pcs_strobe_t;
endpackage

// ---- hdl/pcs_socket.sv ----
// Purpose: Pin drivers for one card socket: address, data, strobes and card reset.
// Assumes: All inputs synchronous to ref_clk; every pin output comes from a flip-flop.
// Notes:   Output enables are high while this socket drives the pin.
`timescale 1ns/1ps
`include "pcs_regs.svh"
module pcs_socket #(
  parameter int AW = `PCS_ADDR_W,
  parameter int DW = `PCS_DATA_W
) (
  input  wire logic                ref_clk,            // 200 MHz clock
  input  wire logic                rst_b,              // Sync reset, active low
  input  wire logic                selected,           // Host has chosen this socket
  input  wire logic                sleep_mode,         // Chip is asleep
  input  wire logic                strobe_float,       // Float bit for this socket's strobes
  input  wire logic                sleep_strobe_float, // In sleep: 1 tristate strobes, 0 drive high while strobe_float is 0
  input  wire logic                sleep_pin_float,    // In sleep: 1 tristate addr/data, 0 drive low
  input  wire logic                sleep_reset_float,  // In sleep: 1 tristate reset, 0 drive low
  input  wire logic                card_reset,         // Reset bit of the card control register
  input  wire logic [AW-1:0]       host_addr,          // Host address
  input  wire logic [DW-1:0]       host_wdata,         // Host write data
  input  wire pcs_pkg::pcs_strobe_t host_strobes_b,    // Host strobes, active low
  input  wire logic                host_writing,       // Host is writing to a card
  output logic      [AW-1:0]       addr,               // Socket address
  output logic                     addr_oe,            // Address enable
  output logic      [DW-1:0]       data_out,           // Socket data out
  output logic                     data_oe,            // Data enable
  output pcs_pkg::pcs_strobe_t     strobes_b,          // Socket strobes, active low
  output logic                     strobes_oe,         // Strobe enable
  output logic                     card_reset_out,     // Card reset, active high
  output logic                     card_reset_oe       // Card reset enable
);
  logic [AW-1:0]        addr_ff;
  logic                 addr_oe_ff;
  logic [DW-1:0]        data_ff;
  logic                 data_oe_ff;
  pcs_pkg::pcs_strobe_t strobes_ff;
  logic                 strobes_oe_ff;
  logic                 reset_ff;
  logic                 reset_oe_ff;

  // Address and data buffers; sleep parks them low or floating
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      addr_ff    <= '0;
      addr_oe_ff <= 1'b1;
      data_ff    <= '0;
      data_oe_ff <= 1'b0;
    end else if (sleep_mode) begin
      addr_ff    <= '0;
      addr_oe_ff <= !sleep_pin_float;
      data_ff    <= '0;
      data_oe_ff <= !sleep_pin_float;
    end else begin
      addr_ff    <= host_addr;
      addr_oe_ff <= 1'b1;
      data_ff    <= host_wdata;
      data_oe_ff <= selected && host_writing;
    end
  end

  // Strobes only reach the selected socket; the other sees them idle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      strobes_ff    <= `PCS_STB_IDLE;
      strobes_oe_ff <= 1'b1;
    end else begin
      strobes_ff    <= (!sleep_mode && selected) ? host_strobes_b : `PCS_STB_IDLE;
      strobes_oe_ff <= !strobe_float && !(sleep_mode && sleep_strobe_float);
    end
  end

  // Chip reset drives the card reset high too
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reset_ff    <= 1'b1;
      reset_oe_ff <= 1'b1;
    end else begin
      reset_ff    <= !sleep_mode && card_reset;
      reset_oe_ff <= !(sleep_mode && sleep_reset_float);
    end
  end

  assign addr           = addr_ff;
  assign addr_oe        = addr_oe_ff;
  assign data_out       = data_ff;
  assign data_oe        = data_oe_ff;
  assign strobes_b      = strobes_ff;
  assign strobes_oe     = strobes_oe_ff;
  assign card_reset_out = reset_ff;
  assign card_reset_oe  = reset_oe_ff;
endmodule

// ---- hdl/pcs_card_if.sv ----
// Purpose: Card socket interface between a host card bus and two sockets.
// Assumes: All inputs synchronous to ref_clk; outputs lag inputs by one clock.
// Notes:   Control bits arrive as plain ports; no register bus in this block.
`timescale 1ns/1ps
`include "pcs_regs.svh"
module pcs_card_if #(
  parameter int AW = `PCS_ADDR_W,
  parameter int DW = `PCS_DATA_W
) (
  input  wire logic                 ref_clk,                  // 200 MHz clock
  input  wire logic                 rst_b,                    // Sync reset, active low
  input  wire logic                 sleep_mode,               // Chip is asleep
  input  wire logic [1:0]           ctl_card_reset,           // Control: per-socket card reset
  input  wire logic [1:0]           ctl_float,                // Control: per-socket strobe float
  input  wire logic [1:0]           ctl_wait_en,              // Control: per-socket wait enable
  input  wire logic [1:0]           sleep_reset_float,        // Sleep state: 1 tristate reset
  input  wire logic                 sleep_strobe_float,       // Sleep state: 1 tristate strobes
  input  wire logic                 sleep_pin_float,          // Sleep state: 1 tristate addr/data
  input  wire logic                 pwr_gpio_wr,              // Write strobe for power pins
  input  wire logic [3:0]           pwr_gpio_wdata,           // Power pin write value
  output logic      [3:0]           pwr_gpio,                 // Power switch pins
  input  wire logic                 socket_select,            // 0 socket zero, 1 socket one
  input  wire logic [AW-1:0]        host_addr,                // Host address
  input  wire logic [DW-1:0]        host_data_in,             // Host write data
  output logic      [DW-1:0]        host_data_out,            // Host read data
  output logic                      host_data_oe,             // Host data enable
  input  wire logic [1:0]           host_card_enables_b,      // Card enables, active low
  input  wire logic                 host_io_read_b,           // I/O read, active low
  input  wire logic                 host_io_write_b,          // I/O write, active low
  input  wire logic                 host_output_enable_b,     // Output enable, active low
  input  wire logic                 host_write_enable_b,      // Write enable, active low
  input  wire logic                 attribute_space_select_b, // Attribute space, active low
  output logic                      host_wait_out_b,          // Wait to host, active low
  output logic                      host_io_width_out_b,      // 16-bit I/O to host, active low
  input  wire logic [DW-1:0]        socket0_data_in,          // Socket 0 data in
  input  wire logic [DW-1:0]        socket1_data_in,          // Socket 1 data in
  input  wire logic                 socket0_io_width_ack_b,   // Socket 0 width ack, active low
  input  wire logic                 socket1_io_width_ack_b,   // Socket 1 width ack, active low
  input  wire logic                 socket0_wait_in_b,        // Socket 0 wait, active low
  input  wire logic                 socket1_wait_in_b,        // Socket 1 wait, active low
  input  wire logic                 socket0_card_detect,      // Socket 0: 0 fully inserted
  input  wire logic                 socket1_card_detect,      // Socket 1: 0 fully inserted
  input  wire logic                 socket0_ready_irq,        // Socket 0 ready/irq pin
  input  wire logic                 socket1_ready_irq,        // Socket 1 ready/irq pin
  input  wire logic                 socket0_status_change,    // Socket 0 status change pin
  input  wire logic                 socket1_status_change,    // Socket 1 status change pin
  output logic      [5:0]           irq_sources,              // {stschg1,cd1,rdy1,stschg0,cd0,rdy0}
  output logic      [AW-1:0]        socket0_addr,             // Socket 0 address
  output logic                      socket0_addr_oe,          // Socket 0 address enable
  output logic      [DW-1:0]        socket0_data_out,         // Socket 0 data out
  output logic                      socket0_data_oe,          // Socket 0 data enable
  output pcs_pkg::pcs_strobe_t      socket0_strobes_b,        // Socket 0 strobes
  output logic                      socket0_strobes_oe,       // Socket 0 strobe enable
  output logic                      socket0_reset,            // Socket 0 card reset
  output logic                      socket0_reset_oe,         // Socket 0 reset enable
  output logic      [AW-1:0]        socket1_addr,             // Socket 1 address
  output logic                      socket1_addr_oe,          // Socket 1 address enable
  output logic      [DW-1:0]        socket1_data_out,         // Socket 1 data out
  output logic                      socket1_data_oe,          // Socket 1 data enable
  output pcs_pkg::pcs_strobe_t      socket1_strobes_b,        // Socket 1 strobes
  output logic                      socket1_strobes_oe,       // Socket 1 strobe enable
  output logic                      socket1_reset,            // Socket 1 card reset
  output logic                      socket1_reset_oe          // Socket 1 reset enable
);
  pcs_pkg::pcs_sock_t   sel;
  pcs_pkg::pcs_strobe_t host_strobes;
  logic                 any_ce;
  logic                 host_writing;
  logic                 host_reading;
  logic                 sel_inserted;
  logic                 sel_ack_b;
  logic                 sel_wait_b;
  logic                 sel_wait_en;
  logic [DW-1:0]        sel_data;
  logic [3:0]           pwr_ff;
  logic [5:0]           irq_ff;
  logic [DW-1:0]        rdata_ff;
  logic                 rdata_oe_ff;
  logic                 wait_ff;
  logic                 width_ff;

  assign sel          = socket_select ? pcs_pkg::PCS_SOCK1 : pcs_pkg::PCS_SOCK0;
  assign any_ce       = !(&host_card_enables_b);
  assign host_writing = any_ce && (!host_io_write_b || !host_write_enable_b);
  assign host_reading = any_ce && (!host_io_read_b || !host_output_enable_b);
  assign host_strobes = {attribute_space_select_b, host_output_enable_b, host_write_enable_b,
                         host_io_write_b, host_io_read_b, host_card_enables_b[1],
                         host_card_enables_b[0]};
  // Card pins are read as they stand, whatever the mode
  always_comb begin
    if (sel == pcs_pkg::PCS_SOCK1) begin
      sel_inserted = !socket1_card_detect;
      sel_ack_b    = socket1_io_width_ack_b;
      sel_wait_b   = socket1_wait_in_b;
      sel_wait_en  = ctl_wait_en[1];
      sel_data     = socket1_data_in;
    end else begin
      sel_inserted = !socket0_card_detect;
      sel_ack_b    = socket0_io_width_ack_b;
      sel_wait_b   = socket0_wait_in_b;
      sel_wait_en  = ctl_wait_en[0];
      sel_data     = socket0_data_in;
    end
  end

  // Return path toward the host; a missing card can never stall it
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wait_ff  <= 1'b1;
      width_ff <= 1'b1;
    end else begin
      wait_ff  <= (any_ce && sel_inserted && sel_wait_en) ? sel_wait_b : 1'b1;
      width_ff <= sel_inserted ? sel_ack_b : 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_ff    <= '0;
      rdata_oe_ff <= 1'b0;
    end else begin
      rdata_ff    <= sel_data;
      rdata_oe_ff <= host_reading;
    end
  end

  // Power pins hold their value between writes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pwr_ff <= `PCS_PWR_RST;
    end else if (pwr_gpio_wr) begin
      pwr_ff <= pwr_gpio_wdata;
    end
  end

  // Raw levels only; edge and polarity handling lives in the interrupt controller
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_ff <= `PCS_IRQ_RST;
    end else begin
      irq_ff <= {socket1_status_change, socket1_card_detect, socket1_ready_irq,
                 socket0_status_change, socket0_card_detect, socket0_ready_irq};
    end
  end

  pcs_socket #(.AW(AW), .DW(DW)) u_sock0 (
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .selected           (sel == pcs_pkg::PCS_SOCK0),
    .sleep_mode         (sleep_mode),
    .strobe_float       (ctl_float[0]),
    .sleep_strobe_float (sleep_strobe_float),
    .sleep_pin_float    (sleep_pin_float),
    .sleep_reset_float  (sleep_reset_float[0]),
    .card_reset         (ctl_card_reset[0]),
    .host_addr          (host_addr),
    .host_wdata         (host_data_in),
    .host_strobes_b     (host_strobes),
    .host_writing       (host_writing),
    .addr               (socket0_addr),
    .addr_oe            (socket0_addr_oe),
    .data_out           (socket0_data_out),
    .data_oe            (socket0_data_oe),
    .strobes_b          (socket0_strobes_b),
    .strobes_oe         (socket0_strobes_oe),
    .card_reset_out     (socket0_reset),
    .card_reset_oe      (socket0_reset_oe)
  );

  pcs_socket #(.AW(AW), .DW(DW)) u_sock1 (
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .selected           (sel == pcs_pkg::PCS_SOCK1),
    .sleep_mode         (sleep_mode),
    .strobe_float       (ctl_float[1]),
    .sleep_strobe_float (sleep_strobe_float),
    .sleep_pin_float    (sleep_pin_float),
    .sleep_reset_float  (sleep_reset_float[1]),
    .card_reset         (ctl_card_reset[1]),
    .host_addr          (host_addr),
    .host_wdata         (host_data_in),
    .host_strobes_b     (host_strobes),
    .host_writing       (host_writing),
    .addr               (socket1_addr),
    .addr_oe            (socket1_addr_oe),
    .data_out           (socket1_data_out),
    .data_oe            (socket1_data_oe),
    .strobes_b          (socket1_strobes_b),
    .strobes_oe         (socket1_strobes_oe),
    .card_reset_out     (socket1_reset),
    .card_reset_oe      (socket1_reset_oe)
  );

  assign pwr_gpio            = pwr_ff;
  assign irq_sources         = irq_ff;
  assign host_data_out       = rdata_ff;
  assign host_data_oe        = rdata_oe_ff;
  assign host_wait_out_b     = wait_ff;
  assign host_io_width_out_b = width_ff;

  // Follow, sleep reset/pins, float and irq antecedents carry rst_b so the reset values that stand just after release are never judged
  a_width_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rst_b && !socket_select && !socket0_card_detect |=> host_io_width_out_b == $past(socket0_io_width_ack_b))
    else $error("width output does not follow socket 0 ack");
  a_width_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    socket_select && socket1_card_detect |=> host_io_width_out_b)
    else $error("width output not high without a card");
  a_wait_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rst_b && socket_select && any_ce && !socket1_card_detect && ctl_wait_en[1]
    |=> host_wait_out_b == $past(socket1_wait_in_b))
    else $error("wait output does not follow socket 1 wait");
  a_wait_blocked: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !socket_select && !ctl_wait_en[0] |=> host_wait_out_b)
    else $error("wait output low with wait disabled");
  a_data_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
    host_data_oe |-> $past(any_ce) && (!$past(host_io_read_b) || !$past(host_output_enable_b)))
    else $error("host data driven without read strobe");
  a_reset_ctl: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !sleep_mode && ctl_card_reset[1] |=> socket1_reset && socket1_reset_oe)
    else $error("socket 1 reset not asserted by control bit");
  a_sleep_reset: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rst_b && sleep_mode) [*2] |-> !socket0_reset && (socket0_reset_oe != $past(sleep_reset_float[0])))
    else $error("socket 0 reset wrong in sleep");
  a_sleep_pins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rst_b && sleep_mode |=> socket1_addr == '0 && socket1_data_oe == !$past(sleep_pin_float))
    else $error("socket 1 address or data wrong in sleep");
  a_float_strobes: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rst_b && ctl_float[0] |=> !socket0_strobes_oe)
    else $error("socket 0 strobes driven while floating");
  a_sleep_strobes: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sleep_mode && !sleep_strobe_float && !ctl_float[1] |=> socket1_strobes_oe && &socket1_strobes_b)
    else $error("socket 1 strobes not high in sleep");
  a_gpio_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pwr_gpio_wr |=> $stable(pwr_gpio))
    else $error("power pins changed without a write");
  a_irq_detect: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rst_b && !socket1_card_detect |=> !irq_sources[4])
    else $error("card detect source not 0 with card inserted");
endmodule

// ---- test/pcs_card_model.sv ----
// Purpose: Behavioural cards seated in both sockets.
// Assumes: Strobe bit order as in pcs_regs.svh; answers are combinational.
// Notes:   A released data bus shows the inverted pattern, so a stale copy never passes.
`timescale 1ns/1ps
`include "pcs_regs.svh"
module pcs_card_model #(
  parameter logic [15:0] PAT0 = 16'h5a3c, // Card 0 read pattern
  parameter logic [15:0] PAT1 = 16'hc3a5  // Card 1 read pattern
) (
  input  wire logic [1:0]           inserted,               // Card fully seated
  input  wire logic [1:0]           io16,                   // Card decodes a 16-bit I/O address
  input  wire logic [1:0]           slow,                   // Card asks for wait states
  input  wire pcs_pkg::pcs_strobe_t socket0_strobes_b,      // Socket 0 strobes
  input  wire pcs_pkg::pcs_strobe_t socket1_strobes_b,      // Socket 1 strobes
  output logic      [15:0]          socket0_data_in,        // Card 0 data
  output logic      [15:0]          socket1_data_in,        // Card 1 data
  output logic                      socket0_io_width_ack_b, // Card 0 width ack
  output logic                      socket1_io_width_ack_b, // Card 1 width ack
  output logic                      socket0_wait_in_b,      // Card 0 wait
  output logic                      socket1_wait_in_b,      // Card 1 wait
  output logic                      socket0_card_detect,    // Card 0 detect
  output logic                      socket1_card_detect     // Card 1 detect
);
  logic [1:0] en;
  logic [1:0] rd;
  assign en = {~&socket1_strobes_b[1:0], ~&socket0_strobes_b[1:0]};
  assign rd = {~(socket1_strobes_b[`PCS_STB_OE] & socket1_strobes_b[`PCS_STB_IOR]),
               ~(socket0_strobes_b[`PCS_STB_OE] & socket0_strobes_b[`PCS_STB_IOR])};
  assign socket0_data_in = (en[0] & rd[0]) ? PAT0 : ~PAT0;
  assign socket1_data_in = (en[1] & rd[1]) ? PAT1 : ~PAT1;
  // Ack follows decode even when half seated, so the bench sees the insertion gate
  assign socket0_io_width_ack_b = ~io16[0];
  assign socket1_io_width_ack_b = ~io16[1];
  assign socket0_wait_in_b = ~(slow[0] & en[0]);
  assign socket1_wait_in_b = ~(slow[1] & en[1]);
  assign socket0_card_detect = ~inserted[0];
  assign socket1_card_detect = ~inserted[1];
endmodule

// ---- test/test_pcs_card_if.sv ----
// Purpose: Self-checking bench for the card socket interface.
// Assumes: Outputs settle within three clocks of a held input set.
// Notes:   Rows cover the host read path; hand tests cover reset, write, sleep, float, power, irqs.
`timescale 1ns/1ps
`include "pcs_regs.svh"
module test_pcs_card_if;
  localparam logic [15:0] PAT0 = 16'h5a3c;
  localparam logic [15:0] PAT1 = 16'hc3a5;
  typedef struct packed {
    logic sel; logic [1:0] ce; logic ior; logic oe; logic [1:0] wen; logic [1:0] ins; logic doe; logic wt; logic wid;
  } pcs_row_t;
  logic ref_clk, rst_b, sleep_mode, sleep_strobe_float, sleep_pin_float, pwr_gpio_wr, socket_select;
  logic host_io_read_b, host_io_write_b, host_output_enable_b, host_write_enable_b, attribute_space_select_b;
  logic host_data_oe, host_wait_out_b, host_io_width_out_b, socket0_io_width_ack_b, socket1_io_width_ack_b;
  logic socket0_wait_in_b, socket1_wait_in_b, socket0_card_detect, socket1_card_detect;
  logic socket0_ready_irq, socket1_ready_irq, socket0_status_change, socket1_status_change;
  logic socket0_addr_oe, socket0_data_oe, socket0_strobes_oe, socket0_reset, socket0_reset_oe;
  logic socket1_addr_oe, socket1_data_oe, socket1_strobes_oe, socket1_reset, socket1_reset_oe;
  logic [1:0] ctl_card_reset, ctl_float, ctl_wait_en, sleep_reset_float, host_card_enables_b, inserted, io16, slow;
  logic [3:0] pwr_gpio_wdata, pwr_gpio;
  logic [5:0] irq_sources;
  logic [25:0] host_addr, socket0_addr, socket1_addr;
  logic [15:0] host_data_in, host_data_out, socket0_data_in, socket1_data_in, socket0_data_out, socket1_data_out;
  pcs_pkg::pcs_strobe_t socket0_strobes_b, socket1_strobes_b;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  pcs_row_t rows [5];
  pcs_card_if dut (.*);
  pcs_card_model #(.PAT0(PAT0), .PAT1(PAT1)) card (.*);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Whole run is near 56 cycles; a hang past this ceiling is a failure
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 500) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    {rst_b, sleep_mode, sleep_strobe_float, sleep_pin_float, pwr_gpio_wr, socket_select} = '0;
    {host_io_read_b, host_io_write_b, host_output_enable_b, host_write_enable_b, attribute_space_select_b} = '1;
    {ctl_card_reset, ctl_float, ctl_wait_en, sleep_reset_float} = '0;
    {host_card_enables_b, inserted, io16, slow} = '1;
    pwr_gpio_wdata = 4'ha;
    host_addr = 26'h2a5_5a5a;
    host_data_in = 16'h1234;
    {socket0_ready_irq, socket1_ready_irq, socket0_status_change, socket1_status_change} = 4'h9;
    rows[0] = '{1'h0, 2'h2, 1'h0, 1'h1, 2'h1, 2'h3, 1'h1, 1'h0, 1'h0};
    rows[1] = '{1'h1, 2'h1, 1'h1, 1'h0, 2'h1, 2'h3, 1'h1, 1'h1, 1'h0};
    rows[2] = '{1'h1, 2'h3, 1'h0, 1'h1, 2'h2, 2'h3, 1'h0, 1'h1, 1'h0};
    rows[3] = '{1'h0, 2'h0, 1'h1, 1'h0, 2'h3, 2'h2, 1'h1, 1'h1, 1'h1};
    rows[4] = '{1'h1, 2'h0, 1'h1, 1'h1, 2'h3, 2'h3, 1'h0, 1'h0, 1'h0};
    repeat (10) @(posedge ref_clk);
    #1;
    chk({socket0_reset, socket1_reset, socket0_reset_oe, pwr_gpio}, 7'h70);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      @(posedge ref_clk);
      socket_select <= rows[i].sel;
      host_card_enables_b <= rows[i].ce;
      host_io_read_b <= rows[i].ior;
      host_output_enable_b <= rows[i].oe;
      ctl_wait_en <= rows[i].wen;
      inserted <= rows[i].ins;
      settle();
      chk(host_data_oe, rows[i].doe);
      chk(host_wait_out_b, rows[i].wt);
      chk(host_io_width_out_b, rows[i].wid);
      if (rows[i].doe) chk(host_data_out, rows[i].sel ? PAT1 : PAT0);
      chk(rows[i].sel ? socket0_strobes_b : socket1_strobes_b, `PCS_STB_IDLE);
      chk(rows[i].sel ? socket1_strobes_b : socket0_strobes_b, {1'b1, rows[i].oe, 2'h3, rows[i].ior, rows[i].ce});
    end
    @(posedge ref_clk);
    socket_select <= 1'b0;
    host_card_enables_b <= 2'h0;
    host_write_enable_b <= 1'b0;
    ctl_card_reset <= 2'h2;
    settle();
    chk({socket0_data_oe, socket1_data_oe, socket0_data_out}, {2'h2, 16'h1234});
    chk({socket0_addr, socket1_addr}, {2{26'h2a5_5a5a}});
    chk({socket1_reset, socket0_reset, socket1_reset_oe}, 3'h5);
    chk(host_data_oe, 1'b0);
    @(posedge ref_clk);
    ctl_float <= 2'h1;
    host_write_enable_b <= 1'b1;
    host_io_write_b <= 1'b0;
    attribute_space_select_b <= 1'b0;
    settle();
    chk(socket0_strobes_oe, 1'b0);
    chk(socket0_strobes_b, 7'h34);
    chk(socket0_data_oe, 1'b1);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      sleep_mode <= 1'b1;
      sleep_pin_float <= k[0];
      sleep_strobe_float <= k[0];
      sleep_reset_float <= k[0] ? 2'h2 : 2'h1;
      ctl_float <= 2'h0;
      settle();
      chk({socket0_addr_oe, socket1_addr_oe, socket1_data_oe, socket1_data_out, socket0_addr},
          {~k[0], ~k[0], ~k[0], 42'h0});
      chk({socket0_strobes_oe, socket1_strobes_oe, socket0_strobes_b}, {~k[0], ~k[0], 7'h7f});
      chk({socket0_reset, socket1_reset, socket0_reset_oe, socket1_reset_oe}, {2'h0, k[0], ~k[0]});
      chk(host_io_width_out_b, 1'b0);
    end
    @(posedge ref_clk);
    sleep_strobe_float <= 1'b0;
    ctl_float <= 2'h2;
    settle();
    chk({socket0_strobes_oe, socket1_strobes_oe}, 2'h2);
    @(posedge ref_clk);
    pwr_gpio_wr <= 1'b1;
    pwr_gpio_wdata <= 4'h5;
    inserted <= 2'h1;
    io16 <= 2'h2;
    @(posedge ref_clk);
    pwr_gpio_wr <= 1'b0;
    pwr_gpio_wdata <= 4'ha;
    settle();
    chk(pwr_gpio, 4'h5);
    chk(host_io_width_out_b, 1'b1);
    chk(irq_sources, 6'h31);
    chk({irq_sources[4], irq_sources[1]}, 2'h2);
    test_done();
  end
endmodule
